// ==== hw/pdcs_dev_ctrl_status.sv ====
// device control and device status registers with request attribute and size checks
//
// Overview of operation
// - function reset initiate bit always reads zero and triggers nothing.
// - read request size field resets to 010; reserved codes 110 and 111.
// - writable no-snoop enable marks granted requests that ask for it as not needing snoop.
// - aux power enable is writable and sticky across function reset.
// - phantom functions enable always zero whatever is written.
// - extended tag enable always zero; outgoing tags use five bits only.
// - payload size field resets to 000; writes limited by supported size.
// - no transmitted payload beyond the limit; received TLPs accepted up to it.
// - relaxed ordering enable resets to one and gates relaxed attribute.
// - bits 3..0 are error reporting enables, each resetting to zero.
// - pending flag set while a non-posted request is outstanding.
// - aux detected reads one when aux enable set and aux power sensed.
// - unsupported request flag set when enabled and such a request seen.
// - fatal error flag set when enabled and a fatal error seen.
// - non-fatal error flag set when enabled and a non-fatal error seen.
// - correctable error flag set when enabled and a correctable error seen.
// - writing one to a set error flag clears it.
`timescale 1ns/10ps
`default_nettype none
module pdcs_dev_ctrl_status
    import pdcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic funcReset,
    input wire logic cfgWrEn,
    input wire logic cfgRdEn,
    input wire logic [7:0] cfgAddr,
    input wire logic [1:0] cfgByteEn,
    input wire logic [15:0] cfgWrData,
    output logic cfgRdValid,
    output logic [15:0] cfgRdData,
    output logic [2:0] readReqLimitCode,
    output logic [2:0] payloadLimitCode,
    output logic noSnoopEn,
    output logic relaxedOrderEn,
    output logic auxPmEn,
    output logic [3:0] errReportEn,
    input wire logic txReqValid,
    input wire logic txReqRead,
    input wire logic txReqNonPosted,
    input wire logic [12:0] txReqLen,
    input wire logic txReqWantRo,
    input wire logic txReqWantNs,
    input wire logic [7:0] txReqTag,
    output logic txGrant,
    output logic txRefuse,
    output logic txAttrRo,
    output logic txAttrNs,
    output logic [7:0] txTag,
    input wire logic rxTlpValid,
    input wire logic [12:0] rxTlpLen,
    output logic rxAccept,
    output logic rxOversize,
    input wire logic npComplete,
    input wire logic npTimeout,
    output logic transPending,
    input wire logic auxPowerSense,
    input wire logic urEvent,
    input wire logic fatalEvent,
    input wire logic nonFatalEvent,
    input wire logic corrEvent,
    output logic [3:0] errMsgReq
);

    logic [2:0] readReqLimit_ff;
    logic [2:0] payloadLimit_ff;
    logic noSnoop_ff;
    logic relaxedOrder_ff;
    logic auxPmEn_ff;
    logic [3:0] errEn_ff;
    logic [3:0] errFlag_ff;
    logic [3:0] nxt_errFlag;
    logic auxDet_ff;
    logic cfgRdValid_ff;
    logic [15:0] cfgRdData_ff;
    logic txGrant_ff;
    logic txRefuse_ff;
    logic txAttrRo_ff;
    logic txAttrNs_ff;
    logic [7:0] txTag_ff;
    logic npIssue_ff;
    logic rxAccept_ff;
    logic rxOversize_ff;
    logic [3:0] errMsgReq_ff;
    logic npPending;
    logic npFull;

    // address decode
    wire logic ctrlHit = (cfgAddr == PDCS_CTRL_OFFSET);
    wire logic statHit = (cfgAddr == PDCS_STAT_OFFSET);
    wire logic ctrlWrHi = cfgWrEn && ctrlHit && cfgByteEn[1];
    wire logic ctrlWrLo = cfgWrEn && ctrlHit && cfgByteEn[0];
    wire logic statWrLo = cfgWrEn && statHit && cfgByteEn[0];

    // field write qualification; illegal codes leave the field as it was
    wire logic [2:0] wrRrs = cfgWrData[PDCS_RRS_LSB+2:PDCS_RRS_LSB];
    wire logic [2:0] wrMps = cfgWrData[PDCS_MPS_LSB+2:PDCS_MPS_LSB];
    wire logic rrsWrOk = ctrlWrHi && (wrRrs <= PDCS_RRS_MAX_CODE);
    wire logic mpsWrOk = ctrlWrLo && (wrMps <= PDCS_MPS_SUPPORTED);

    // non-sticky control fields; function reset returns them to reset values
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            readReqLimit_ff <= PDCS_RRS_RST;
            payloadLimit_ff <= PDCS_MPS_RST;
            noSnoop_ff <= PDCS_NS_RST;
            relaxedOrder_ff <= PDCS_RO_RST;
            errEn_ff <= PDCS_ERREN_RST;
        end
        else if (funcReset)
        begin
            readReqLimit_ff <= PDCS_RRS_RST;
            payloadLimit_ff <= PDCS_MPS_RST;
            noSnoop_ff <= PDCS_NS_RST;
            relaxedOrder_ff <= PDCS_RO_RST;
            errEn_ff <= PDCS_ERREN_RST;
        end
        else
        begin
            if (rrsWrOk)
                readReqLimit_ff <= wrRrs;
            if (mpsWrOk)
                payloadLimit_ff <= wrMps;
            if (ctrlWrHi)
                noSnoop_ff <= cfgWrData[PDCS_NS_BIT];
            if (ctrlWrLo)
            begin
                relaxedOrder_ff <= cfgWrData[PDCS_RO_BIT];
                errEn_ff <= cfgWrData[PDCS_ERREN_LSB+3:PDCS_ERREN_LSB];
            end
        end
    end

    // sticky bit: only the full reset clears it, function reset does not
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            auxPmEn_ff <= PDCS_AUX_RST;
        else if (ctrlWrHi)
            auxPmEn_ff <= cfgWrData[PDCS_AUX_BIT];
    end

    // error flags: set wins over a clearing write in the same cycle
    wire logic [3:0] errEvent = {urEvent, fatalEvent, nonFatalEvent, corrEvent};
    wire logic [3:0] errSet = errEvent & errEn_ff;
    wire logic [3:0] errClr = statWrLo ? cfgWrData[PDCS_ERR_LSB+3:PDCS_ERR_LSB] : 4'h0;
    assign nxt_errFlag = (errFlag_ff & ~errClr) | errSet;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            errFlag_ff <= 4'h0;
            errMsgReq_ff <= 4'h0;
            auxDet_ff <= 1'h0;
        end
        else
        begin
            errFlag_ff <= nxt_errFlag;
            errMsgReq_ff <= errSet;
            auxDet_ff <= auxPmEn_ff && auxPowerSense;
        end
    end

    // register views; fixed and reserved bits read as zero
    wire logic [15:0] ctrlView = {1'h0, readReqLimit_ff, noSnoop_ff, auxPmEn_ff, 1'h0, 1'h0,
                                  payloadLimit_ff, relaxedOrder_ff, errEn_ff};
    wire logic [15:0] statView = {10'h000, npPending, auxDet_ff, errFlag_ff};
    wire logic [15:0] rdMux = ctrlHit ? ctrlView : (statHit ? statView : 16'h0000);

    // read data held in a register, valid one cycle after the request
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cfgRdValid_ff <= 1'h0;
            cfgRdData_ff <= 16'h0000;
        end
        else
        begin
            cfgRdValid_ff <= cfgRdEn;
            if (cfgRdEn)
                cfgRdData_ff <= rdMux;
        end
    end

    // outgoing request check against the configured sizes
    wire logic npReq = txReqRead || txReqNonPosted;
    wire logic [12:0] txLimit = txReqRead ? pdcs_size_bytes(readReqLimit_ff) : pdcs_size_bytes(payloadLimit_ff);
    wire logic txLenOk = (txReqLen <= txLimit);
    wire logic txOk = txLenOk && !(npReq && npFull);
    wire logic [12:0] rxLimit = pdcs_size_bytes(payloadLimit_ff);

    // grant carries attributes only as far as the enables allow
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            txGrant_ff <= 1'h0;
            txRefuse_ff <= 1'h0;
            txAttrRo_ff <= 1'h0;
            txAttrNs_ff <= 1'h0;
            txTag_ff <= 8'h00;
            npIssue_ff <= 1'h0;
        end
        else
        begin
            txGrant_ff <= txReqValid && txOk;
            txRefuse_ff <= txReqValid && !txOk;
            txAttrRo_ff <= txReqValid && txOk && txReqWantRo && relaxedOrder_ff;
            txAttrNs_ff <= txReqValid && txOk && txReqWantNs && noSnoop_ff;
            txTag_ff <= {3'h0, txReqTag[PDCS_TAG_W-1:0]};
            npIssue_ff <= txReqValid && txOk && npReq;
        end
    end

    // receive side size check
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rxAccept_ff <= 1'h0;
            rxOversize_ff <= 1'h0;
        end
        else
        begin
            rxAccept_ff <= rxTlpValid && (rxTlpLen <= rxLimit);
            rxOversize_ff <= rxTlpValid && (rxTlpLen > rxLimit);
        end
    end

    // outstanding non-posted tracking; completion and timeout both retire
    pdcs_np_tracker u_np (
        .clk(clk),
        .rst(rst),
        .clear(funcReset),
        .issue(npIssue_ff),
        .retire(npComplete || npTimeout),
        .outstanding(),
        .pending(npPending),
        .full(npFull)
    );

    assign cfgRdValid = cfgRdValid_ff;
    assign cfgRdData = cfgRdData_ff;
    assign readReqLimitCode = readReqLimit_ff;
    assign payloadLimitCode = payloadLimit_ff;
    assign noSnoopEn = noSnoop_ff;
    assign relaxedOrderEn = relaxedOrder_ff;
    assign auxPmEn = auxPmEn_ff;
    assign errReportEn = errEn_ff;
    assign txGrant = txGrant_ff;
    assign txRefuse = txRefuse_ff;
    assign txAttrRo = txAttrRo_ff;
    assign txAttrNs = txAttrNs_ff;
    assign txTag = txTag_ff;
    assign rxAccept = rxAccept_ff;
    assign rxOversize = rxOversize_ff;
    assign transPending = npPending;
    assign errMsgReq = errMsgReq_ff;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_ctrlRead;
        cfgRdEn && ctrlHit ##1 cfgRdValid_ff;
    endsequence

    sequence s_npIssued;
        txReqValid && txOk && npReq ##1 npIssue_ff;
    endsequence

    sequence s_statRead;
        cfgRdEn && statHit ##1 cfgRdValid_ff;
    endsequence

    a_flr_reads_zero: assert property (s_ctrlRead |-> !cfgRdData_ff[PDCS_FLR_BIT])
        else $error("function reset initiate bit read as one");
    a_rrs_reserved_kept: assert property (ctrlWrHi && (wrRrs > PDCS_RRS_MAX_CODE) && !funcReset
        |=> readReqLimit_ff == $past(readReqLimit_ff))
        else $error("reserved read request code was stored");
    a_nosnoop_attr: assert property (txAttrNs_ff |-> $past(noSnoop_ff) && $past(txReqWantNs))
        else $error("no-snoop attribute set while disabled");
    a_aux_sticky: assert property (funcReset && !ctrlWrHi |=> auxPmEn_ff == $past(auxPmEn_ff))
        else $error("aux power enable lost on function reset");
    a_fixed_bits_zero: assert property (s_ctrlRead |-> cfgRdData_ff[PDCS_PH_BIT:PDCS_ET_BIT] == 2'h0)
        else $error("phantom or extended tag enable read as one");
    a_tag_five_bits: assert property (txGrant_ff |-> txTag_ff == {3'h0, $past(txReqTag[4:0])})
        else $error("granted request carries a tag above five bits");
    a_payload_legal: assert property (payloadLimit_ff <= PDCS_MPS_SUPPORTED)
        else $error("payload limit beyond supported size");
    a_tx_len_bound: assert property (txReqValid && !txReqRead && (txReqLen > pdcs_size_bytes(payloadLimit_ff))
        |=> !txGrant_ff && txRefuse_ff)
        else $error("oversize payload was granted");
    a_rx_len_accept: assert property (rxTlpValid && (rxTlpLen <= rxLimit) |=> rxAccept_ff && !rxOversize_ff)
        else $error("in-limit packet not accepted");
    a_ro_attr: assert property (txAttrRo_ff |-> $past(relaxedOrder_ff))
        else $error("relaxed attribute set while disabled");
    a_en_reset_value: assert property ($fell(rst) |-> errEn_ff == PDCS_ERREN_RST && relaxedOrder_ff)
        else $error("enables not at reset value");
    a_pending_on_issue: assert property (s_npIssued ##0 !funcReset |=> transPending)
        else $error("pending flag not set after non-posted issue");
    a_aux_detected: assert property (##1 auxDet_ff == ($past(auxPmEn_ff) && $past(auxPowerSense)))
        else $error("aux detected does not follow enable and sense");
    a_ur_set: assert property (urEvent && errEn_ff[PDCS_ERR_UR] |=> errFlag_ff[PDCS_ERR_UR])
        else $error("unsupported request flag not set");
    a_fatal_set: assert property (fatalEvent && errEn_ff[PDCS_ERR_FATAL] |=> errFlag_ff[PDCS_ERR_FATAL])
        else $error("fatal error flag not set");
    a_nonfatal_set: assert property (nonFatalEvent && errEn_ff[PDCS_ERR_NONFATAL]
        |=> errFlag_ff[PDCS_ERR_NONFATAL])
        else $error("non-fatal error flag not set");
    a_corr_set: assert property (corrEvent && errEn_ff[PDCS_ERR_CORR] |=> errFlag_ff[PDCS_ERR_CORR])
        else $error("correctable error flag not set");
    a_w1c_clears: assert property (statWrLo && (errSet == 4'h0)
        |=> (errFlag_ff & $past(cfgWrData[3:0])) == 4'h0)
        else $error("write of one did not clear flag");
    a_w0_keeps: assert property ((errClr == 4'h0) |=> (errFlag_ff & $past(errFlag_ff)) == $past(errFlag_ff))
        else $error("flag changed without a clearing write");
    a_stat_reserved: assert property (s_statRead |-> cfgRdData_ff[15:PDCS_TP_BIT+1] == 10'h000)
        else $error("reserved status bits read as one");
    a_rrs_write: assert property (rrsWrOk && !funcReset |=> readReqLimit_ff == $past(wrRrs))
        else $error("legal read request code not stored");
    a_nosnoop_write: assert property (ctrlWrHi && !funcReset
        |=> noSnoop_ff == $past(cfgWrData[PDCS_NS_BIT]))
        else $error("no-snoop enable not written");
    a_aux_write: assert property (ctrlWrHi |=> auxPmEn_ff == $past(cfgWrData[PDCS_AUX_BIT]))
        else $error("aux power enable not written");
    a_ro_write: assert property (ctrlWrLo && !funcReset
        |=> relaxedOrder_ff == $past(cfgWrData[PDCS_RO_BIT]))
        else $error("relaxed ordering enable not written");
    a_en_write: assert property (ctrlWrLo && !funcReset |=> errEn_ff == $past(cfgWrData[3:0]))
        else $error("error reporting enables not written");
    a_rx_oversize: assert property (rxTlpValid && (rxTlpLen > rxLimit) |=> rxOversize_ff && !rxAccept_ff)
        else $error("oversize packet not flagged");

endmodule
`default_nettype wire

// ==== hw/pdcs_np_tracker.sv ====
// counter of outstanding non-posted requests and the pending flag
`timescale 1ns/10ps
`default_nettype none
module pdcs_np_tracker
    import pdcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic issue,
    input wire logic retire,
    output logic [5:0] outstanding,
    output logic pending,
    output logic full
);

    logic [5:0] count_ff;
    logic [5:0] nxt_count;
    logic pending_ff;
    logic full_ff;
    wire logic doIssue;
    wire logic doRetire;

    // retire with nothing outstanding is ignored, issue when full is refused
    assign doIssue = issue && (count_ff != PDCS_NP_MAX);
    assign doRetire = retire && (count_ff != 6'h00);
    assign nxt_count = clear ? 6'h00 :
                       (doIssue && !doRetire) ? count_ff + 6'h01 :
                       (!doIssue && doRetire) ? count_ff - 6'h01 : count_ff;

    // flag follows the count in the same edge, so it never lags a completion
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            count_ff <= 6'h00;
            pending_ff <= 1'h0;
            full_ff <= 1'h0;
        end
        else
        begin
            count_ff <= nxt_count;
            pending_ff <= (nxt_count != 6'h00);
            full_ff <= (nxt_count == PDCS_NP_MAX);
        end
    end

    assign outstanding = count_ff;
    assign pending = pending_ff;
    assign full = full_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_pending_tracks_count: assert property (pending_ff == (count_ff != 6'h00))
        else $error("pending flag disagrees with outstanding count");
    a_last_retire_clears: assert property ((count_ff == 6'h01) && retire && !issue |=> !pending_ff)
        else $error("pending flag stayed set after last completion");

endmodule
`default_nettype wire

// ==== hw/pdcs_pkg.sv ====
// constants, field layout and helpers for the device control and status registers
package pdcs_pkg;

    // register offsets inside the express capability
    localparam logic [7:0] PDCS_CTRL_OFFSET = 8'h08;
    localparam logic [7:0] PDCS_STAT_OFFSET = 8'h0a;

    // control register field positions
    localparam int PDCS_FLR_BIT = 15;
    localparam int PDCS_RRS_LSB = 12;
    localparam int PDCS_NS_BIT = 11;
    localparam int PDCS_AUX_BIT = 10;
    localparam int PDCS_PH_BIT = 9;
    localparam int PDCS_ET_BIT = 8;
    localparam int PDCS_MPS_LSB = 5;
    localparam int PDCS_RO_BIT = 4;
    localparam int PDCS_ERREN_LSB = 0;

    // status register field positions
    localparam int PDCS_TP_BIT = 5;
    localparam int PDCS_AUXD_BIT = 4;
    localparam int PDCS_ERR_LSB = 0;

    // error vector bit order
    localparam int PDCS_ERR_UR = 3;
    localparam int PDCS_ERR_FATAL = 2;
    localparam int PDCS_ERR_NONFATAL = 1;
    localparam int PDCS_ERR_CORR = 0;

    // values after reset
    localparam logic [2:0] PDCS_RRS_RST = 3'h2;
    localparam logic [2:0] PDCS_MPS_RST = 3'h0;
    localparam logic PDCS_NS_RST = 1'h0;
    localparam logic PDCS_AUX_RST = 1'h0;
    localparam logic PDCS_RO_RST = 1'h1;
    localparam logic [3:0] PDCS_ERREN_RST = 4'h0;

    // legal code limits
    localparam logic [2:0] PDCS_RRS_MAX_CODE = 3'h5;
    localparam logic [2:0] PDCS_MPS_SUPPORTED = 3'h2;

    // widths and counts
    localparam int PDCS_LEN_W = 13;
    localparam int PDCS_TAG_W = 5;
    localparam int PDCS_NP_W = 6;
    localparam logic [5:0] PDCS_NP_MAX = 6'h20;

    // size code to bytes: 000 is 128, each step doubles
    function automatic logic [12:0] pdcs_size_bytes(input logic [2:0] code);
        pdcs_size_bytes = 13'h0080 << code;
    endfunction

endpackage

// ==== tb/pdcs_dev_ctrl_status_bench.sv ====
// bench for the device control and status registers
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module pdcs_dev_ctrl_status_bench
    import pdcs_pkg::*;
;
    logic clk, rst, funcReset, cfgWrEn, cfgRdEn, cfgRdValid, noSnoopEn, relaxedOrderEn, auxPmEn;
    logic [7:0] cfgAddr, txReqTag, txTag;
    logic [1:0] cfgByteEn;
    logic [15:0] cfgWrData, cfgRdData, rd;
    logic [2:0] readReqLimitCode, payloadLimitCode;
    logic txReqValid, txReqRead, txReqNonPosted, txReqWantRo, txReqWantNs;
    logic [3:0] errReportEn, errMsgReq, evt;
    logic [12:0] txReqLen, rxTlpLen;
    logic txGrant, txRefuse, txAttrRo, txAttrNs, rxTlpValid, rxAccept, rxOversize;
    logic npComplete, npTimeout, transPending, auxPowerSense, hold;
    int n_fail, n_tests;
    localparam logic [7:0] C = PDCS_CTRL_OFFSET;
    localparam logic [7:0] S = PDCS_STAT_OFFSET;

    pdcs_dev_ctrl_status u_pdcs_dev_ctrl_status (.clk, .rst, .funcReset, .cfgWrEn, .cfgRdEn, .cfgAddr, .cfgByteEn,
        .cfgWrData, .cfgRdValid, .cfgRdData, .readReqLimitCode, .payloadLimitCode, .noSnoopEn, .relaxedOrderEn,
        .auxPmEn, .errReportEn, .txReqValid, .txReqRead, .txReqNonPosted, .txReqLen, .txReqWantRo, .txReqWantNs,
        .txReqTag, .txGrant, .txRefuse, .txAttrRo, .txAttrNs, .txTag, .rxTlpValid, .rxTlpLen, .rxAccept,
        .rxOversize, .npComplete, .npTimeout, .transPending, .auxPowerSense, .urEvent(evt[3]),
        .fatalEvent(evt[2]), .nonFatalEvent(evt[1]), .corrEvent(evt[0]), .errMsgReq);
    pdcs_host_model #(.LAT(4)) u_pdcs_host_model (.clk, .rst, .hold, .txReqValid, .txReqRead, .txReqNonPosted,
        .txGrant, .npTimeout, .npComplete);

    // free running clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // bus cycles: inputs move at the falling edge, results read a falling edge later
    task automatic cfg_wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        cfgWrEn = 1'b1;
        cfgAddr = a;
        cfgWrData = d;
        @(negedge clk);
        cfgWrEn = 1'b0;
    endtask
    task automatic cfg_rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk);
        cfgRdEn = 1'b1;
        cfgAddr = a;
        @(negedge clk);
        cfgRdEn = 1'b0;
        `CHK(cfgRdValid, 1'b1)
        d = cfgRdData;
    endtask
    task automatic tx(input logic r, input logic np, input logic [12:0] len, input logic ro, input logic [7:0] tg);
        @(negedge clk);
        {txReqValid, txReqRead, txReqNonPosted, txReqLen, txReqWantRo, txReqWantNs, txReqTag} = {1'b1, r, np, len, ro,
            1'b1, tg};
        @(negedge clk);
        txReqValid = 1'b0;
    endtask
    task automatic rx(input logic [12:0] len);
        @(negedge clk);
        rxTlpValid = 1'b1;
        rxTlpLen = len;
        @(negedge clk);
        rxTlpValid = 1'b0;
    endtask
    task automatic pulse(input logic [3:0] e);
        @(negedge clk);
        evt = e;
        @(negedge clk);
        evt = 4'h0;
    endtask

    task automatic stop_test();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // reset values of both registers
    task automatic t_reset();
        cfg_rd(C, rd);
        `CHK(rd, 16'h2010)
        cfg_rd(S, rd);
        `CHK(rd, 16'h0000)
        $display("test reset done");
    endtask
    // fixed bits, reserved codes and unmapped place
    task automatic t_ctrl();
        cfg_wr(C, 16'hffff);
        cfg_rd(C, rd);
        `CHK(rd, 16'h2c1f)
        `CHK({noSnoopEn, auxPmEn, errReportEn}, 6'h3f)
        cfg_wr(C, 16'h5040);
        cfg_rd(C, rd);
        `CHK(rd, 16'h5040)
        `CHK({readReqLimitCode, payloadLimitCode, relaxedOrderEn}, 7'h54)
        cfg_wr(8'h0c, 16'hffff);
        cfg_rd(8'h0c, rd);
        `CHK(rd, 16'h0000)
        cfg_wr(S, 16'hffe0);
        cfg_rd(S, rd);
        `CHK(rd, 16'h0000)
        cfg_wr(C, 16'h0400);
        @(negedge clk);
        funcReset = 1'b1;
        @(negedge clk);
        funcReset = 1'b0;
        cfg_rd(C, rd);
        `CHK(rd, 16'h2410)
        $display("test control done");
    endtask
    // size limits at the boundary, attributes and tag width
    task automatic t_tx();
        cfg_wr(C, 16'h5810);
        tx(1'b1, 1'b0, 13'd4096, 1'b1, 8'hff);
        `CHK({txGrant, txRefuse, txAttrRo, txAttrNs, txTag}, 12'hb1f)
        tx(1'b1, 1'b0, 13'd4097, 1'b1, 8'hff);
        `CHK({txGrant, txRefuse, txAttrRo, txAttrNs, txTag}, 12'h41f)
        tx(1'b0, 1'b0, 13'd128, 1'b0, 8'h25);
        `CHK({txGrant, txRefuse, txTag}, 10'h205)
        tx(1'b0, 1'b0, 13'd129, 1'b0, 8'h25);
        `CHK({txGrant, txRefuse}, 2'h1)
        cfg_wr(C, 16'h5000);
        tx(1'b0, 1'b0, 13'd64, 1'b1, 8'h00);
        `CHK({txGrant, txAttrRo, txAttrNs}, 3'h4)
        rx(13'd128);
        `CHK({rxAccept, rxOversize}, 2'h2)
        rx(13'd129);
        `CHK({rxAccept, rxOversize}, 2'h1)
        $display("test requests done");
    endtask
    // pending flag through timeout and through a normal completion of a second request
    task automatic t_pend();
        int k;
        hold = 1'b1;
        tx(1'b0, 1'b1, 13'd16, 1'b0, 8'h01);
        cfg_rd(S, rd);
        `CHK(rd[5], 1'b1)
        @(negedge clk);
        npTimeout = 1'b1;
        @(negedge clk);
        npTimeout = 1'b0;
        cfg_rd(S, rd);
        `CHK(rd[5], 1'b0)
        hold = 1'b0;
        tx(1'b1, 1'b0, 13'd32, 1'b0, 8'h02);
        cfg_rd(S, rd);
        `CHK(rd[5], 1'b1)
        for (k = 0; k < 40 && transPending !== 1'b0; k++)
            @(negedge clk);
        if (k == 40)
        begin
            `CHK(transPending, 1'b0)
            stop_test();
        end
        cfg_rd(S, rd);
        `CHK(rd[5], 1'b0)
        $display("test pending done");
    endtask
    // aux power seen only with the enable set
    task automatic t_aux();
        auxPowerSense = 1'b1;
        cfg_rd(S, rd);
        `CHK(rd[4], 1'b0)
        cfg_wr(C, 16'h0400);
        cfg_rd(S, rd);
        `CHK(rd[4], 1'b1)
        auxPowerSense = 1'b0;
        cfg_rd(S, rd);
        `CHK(rd[4], 1'b0)
        $display("test aux done");
    endtask
    // each error kind: ignored while disabled, set, kept by zero, cleared by one
    task automatic t_err();
        for (int i = 0; i < 4; i++)
        begin
            cfg_wr(C, 16'h0000);
            pulse(4'h1 << i);
            `CHK(errMsgReq, 4'h0)
            cfg_rd(S, rd);
            `CHK(rd[3:0], 4'h0)
            cfg_wr(C, 16'h0001 << i);
            pulse(4'h1 << i);
            `CHK(errMsgReq, 4'h1 << i)
            cfg_wr(S, 16'h0000);
            cfg_rd(S, rd);
            `CHK(rd[3:0], 4'h1 << i)
            cfg_wr(S, 16'h0001 << i);
            cfg_rd(S, rd);
            `CHK(rd[3:0], 4'h0)
        end
        $display("test errors done");
    endtask

    // main sequence
    initial
    begin
        {rst, funcReset, cfgWrEn, cfgRdEn, cfgAddr, cfgWrData, evt} = {1'b1, 31'h0};
        {txReqValid, txReqRead, txReqNonPosted, txReqLen, txReqWantRo, txReqWantNs, txReqTag} = 26'h0;
        {rxTlpValid, rxTlpLen, npTimeout, auxPowerSense, hold} = 17'h0;
        cfgByteEn = 2'h3;
        n_fail = 0;
        n_tests = 0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_ctrl();
        t_tx();
        t_pend();
        t_aux();
        t_err();
        stop_test();
    end
endmodule
`default_nettype wire

// ==== tb/pdcs_host_model.sv ====
// host side model: completes granted non-posted requests after a delay
`timescale 1ns/10ps
`default_nettype none
module pdcs_host_model
    import pdcs_pkg::*;
#(
    parameter int LAT = 4
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic hold,
    input wire logic txReqValid,
    input wire logic txReqRead,
    input wire logic txReqNonPosted,
    input wire logic txGrant,
    input wire logic npTimeout,
    output logic npComplete
);
    logic np1_ff;
    logic [7:0] wait_ff;
    // one request in flight; a timeout drops it so no stray completion follows
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            np1_ff <= 1'b0;
            wait_ff <= 8'h00;
            npComplete <= 1'b0;
        end
        else
        begin
            np1_ff <= txReqValid & (txReqRead | txReqNonPosted); // lines up with the grant pulse
            npComplete <= 1'b0;
            if (npTimeout)
                wait_ff <= 8'h00;
            else if (txGrant & np1_ff)
                wait_ff <= 8'(LAT);
            else if (wait_ff != 8'h00 && !hold)
            begin
                wait_ff <= wait_ff - 8'h01;
                npComplete <= (wait_ff == 8'h01); // completion returns
            end
        end
    end
endmodule
`default_nettype wire
